// [wdc_defines.svh]
// Register map, field positions, reset values and timing counts of the watchdog control block
// How it works
// - Time-out in interrupt mode sets the flag
// - Vector execution clears the flag
// - Writing one clears flag, zero keeps
// - Request needs flag, enable and global enable
// - Enable bits select stop, irq, reset, both
// - Programmed fuse forces reset mode always
// - Combined mode: first time-out only interrupts
// - Vector clears enable and flag, reset mode
// - Unserviced flag at next time-out resets
// - Reset clear, prescale change need change-enable
// - Change-enable self-clears after four cycles
// - Cause flag holds reset enable set
// - Prescale bits at 5 and 2..0
// - Time-out is 2048 shifted by code
// - Watchdog reset starts at vector 0x0000
// - Counts oscillator ticks, restart instruction clears
// - Watchdog reset sets cause, zero write clears
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH

`define WDC_ADDR_W 4
`define WDC_DATA_W 32
`define WDC_VEC_W 16
`define WDC_CNT_W 21

`define WDC_OFF_CTRL 4'h0
`define WDC_OFF_CAUSE 4'h4

`define WDC_BIT_FLAG 7
`define WDC_BIT_IE 6
`define WDC_BIT_PS3 5
`define WDC_BIT_CE 4
`define WDC_BIT_SRE 3
`define WDC_BIT_CAUSE 3

`define WDC_CE_CYCLES 3'h4
`define WDC_BASE_CYCLES 21'h000800
`define WDC_CNT_ONE 21'h000001
`define WDC_PS_MAX 4'h9
`define WDC_PS_RESET 4'h0
`define WDC_RESET_VECTOR 16'h0000

`endif

// [wdc_pkg.sv]
// Types shared by the watchdog control block
`include "wdc_defines.svh"
package wdc_pkg;
    typedef logic [`WDC_ADDR_W-1:0] wdc_addr_t;
    typedef logic [`WDC_DATA_W-1:0] wdc_word_t;
    typedef logic [`WDC_VEC_W-1:0] wdc_vec_t;
    typedef logic [3:0] wdc_ps_t;
    typedef enum logic [3:0] {
        WDC_STOP = 4'b0001,
        WDC_IRQ  = 4'b0010,
        WDC_RST  = 4'b0100,
        WDC_BOTH = 4'b1000
    } wdc_mode_e;
endpackage

// [wdc_cnt_if.sv]
// Link between the control logic and the time-out counter
`timescale 1ns/1ps
`default_nettype none
interface wdc_cnt_if;
    logic tick;
    logic restart;
    logic run;
    logic [3:0] sel;
    logic timeout;
    modport ctrl (output tick, output restart, output run, output sel, input timeout);
    modport cnt (input tick, input restart, input run, input sel, output timeout);
endinterface
`default_nettype wire

// [wdc_timer.sv]
// Time-out counter clocked by oscillator ticks
`timescale 1ns/1ps
`default_nettype none
`include "wdc_defines.svh"
module wdc_timer (
    input wire logic mclk,
    input wire logic nrst,
    wdc_cnt_if.cnt cif
);
    import wdc_pkg::*;

    logic [`WDC_CNT_W-1:0] count;
    logic [`WDC_CNT_W-1:0] next_count;
    logic [`WDC_CNT_W-1:0] limit;
    logic timeout;
    logic next_timeout;
    wdc_ps_t eff_sel;

    always_comb begin
        eff_sel = (cif.sel > `WDC_PS_MAX) ? `WDC_PS_MAX : cif.sel;
        limit = `WDC_BASE_CYCLES << eff_sel;
        next_count = count;
        next_timeout = 1'b0;
        if (cif.restart || !cif.run) begin
            next_count = '0;
        end else if (cif.tick) begin
            // Greater-or-equal so a switch to a shorter period fires on the next tick
            if (count >= limit - `WDC_CNT_ONE) begin
                next_count = '0;
                next_timeout = 1'b1;
            end else begin
                next_count = count + `WDC_CNT_ONE;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            timeout <= 1'b0;
        end else begin
            count <= next_count;
            timeout <= next_timeout;
        end
    end

    assign cif.timeout = timeout;

    property p_timeout_limit;
        @(posedge mclk) disable iff (!nrst)
        timeout |-> $past(count) >= $past(limit) - `WDC_CNT_ONE;
    endproperty
    a_timeout_limit: assert property (p_timeout_limit) else $error("time-out before limit");

    property p_restart_clears;
        @(posedge mclk) disable iff (!nrst)
        cif.restart |=> count == '0 && !timeout;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear counter");
endmodule
`default_nettype wire

// [wdc_ctrl.sv]
// Watchdog control, status, mode selection and register slave
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wdc_defines.svh"
module wdc_ctrl (
    input wire logic mclk,
    input wire logic nrst,
    input wire wdc_pkg::wdc_addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire wdc_pkg::wdc_word_t avs_writedata,
    output wdc_pkg::wdc_word_t avs_readdata,
    output logic avs_waitrequest,
    input wire logic osc_pin,
    input wire logic always_on_fuse,
    input wire logic wdr_exec,
    input wire logic irq_vector_exec,
    input wire logic global_irq_enable,
    output logic irq_req,
    output logic sys_reset,
    output wdc_pkg::wdc_vec_t reset_vector
);
    import wdc_pkg::*;

    wdc_cnt_if cif ();

    wdc_timer u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .cif(cif)
    );

    // Pin synchronisers; the third oscillator stage only feeds edge detection
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic fuse_s1;
    logic fuse_s2;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            fuse_s1 <= 1'b1;
            fuse_s2 <= 1'b1;
        end else begin
            osc_s1 <= osc_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            fuse_s1 <= always_on_fuse;
            fuse_s2 <= fuse_s1;
        end
    end

    // Control state
    logic flag;
    logic ie;
    logic sre;
    wdc_ps_t ps;
    logic [2:0] ce_cnt;
    logic cause;
    logic next_flag;
    logic next_ie;
    logic next_sre;
    wdc_ps_t next_ps;
    logic [2:0] next_ce_cnt;
    logic next_cause;

    logic fuse_prog;
    logic sre_eff;
    logic ie_eff;
    logic ce;
    wdc_mode_e mode;
    logic to_irq;
    logic to_rst;
    logic wr;
    logic wr_ctrl;
    logic wr_cause;
    wdc_word_t wd;
    wdc_word_t rd_ctrl;
    wdc_word_t rd_cause;

    always_comb begin
        fuse_prog = !fuse_s2;
        sre_eff = sre || cause || fuse_prog;
        ie_eff = ie && !fuse_prog;
        ce = (ce_cnt != 3'h0);
        if (fuse_prog) begin
            mode = WDC_RST;
        end else begin
            case ({sre || cause, ie})
                2'b00: mode = WDC_STOP;
                2'b01: mode = WDC_IRQ;
                2'b10: mode = WDC_RST;
                default: mode = WDC_BOTH;
            endcase
        end
        to_irq = cif.timeout && (mode == WDC_IRQ || (mode == WDC_BOTH && !flag));
        to_rst = cif.timeout && (mode == WDC_RST || (mode == WDC_BOTH && flag));
        wd = avs_writedata;
        wr = avs_write && !avs_waitrequest;
        wr_ctrl = 1'b0;
        wr_cause = 1'b0;
        if (avs_address == `WDC_OFF_CTRL) begin
            wr_ctrl = wr;
        end else if (avs_address == `WDC_OFF_CAUSE) begin
            wr_cause = wr;
        end
        rd_ctrl = '0;
        rd_ctrl[`WDC_BIT_FLAG] = flag;
        rd_ctrl[`WDC_BIT_IE] = ie_eff;
        rd_ctrl[`WDC_BIT_PS3] = ps[3];
        rd_ctrl[`WDC_BIT_CE] = ce;
        rd_ctrl[`WDC_BIT_SRE] = sre_eff;
        rd_ctrl[2:0] = ps[2:0];
        rd_cause = '0;
        rd_cause[`WDC_BIT_CAUSE] = cause;
    end

    always_comb begin
        next_flag = flag;
        next_ie = ie;
        next_sre = sre;
        next_ps = ps;
        next_ce_cnt = ce_cnt;
        next_cause = cause;
        if (wr_ctrl && wd[`WDC_BIT_FLAG]) begin
            next_flag = 1'b0;
        end
        if (wr_ctrl) begin
            next_ie = wd[`WDC_BIT_IE];
            if (wd[`WDC_BIT_SRE]) begin
                next_sre = 1'b1;
            end else if (ce && !cause) begin
                next_sre = 1'b0;
            end
            if (ce) begin
                next_ps = {wd[`WDC_BIT_PS3], wd[2:0]};
            end
        end
        // Vector execution drops the combined mode back to plain reset mode
        if (irq_vector_exec) begin
            next_flag = 1'b0;
            if (sre_eff) begin
                next_ie = 1'b0;
            end
        end
        // A time-out in the same cycle as a clear still lands
        if (to_irq) begin
            next_flag = 1'b1;
        end
        if (wr_ctrl && wd[`WDC_BIT_CE]) begin
            next_ce_cnt = `WDC_CE_CYCLES;
        end else if (ce) begin
            next_ce_cnt = ce_cnt - 3'h1;
        end
        if (wr_cause && !wd[`WDC_BIT_CAUSE]) begin
            next_cause = 1'b0;
        end
        if (to_rst) begin
            next_cause = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
            ie <= 1'b0;
            sre <= 1'b0;
            ps <= `WDC_PS_RESET;
            ce_cnt <= 3'h0;
            cause <= 1'b0;
        end else begin
            flag <= next_flag;
            ie <= next_ie;
            sre <= next_sre;
            ps <= next_ps;
            ce_cnt <= next_ce_cnt;
            cause <= next_cause;
        end
    end

    // Counter hookup
    always_comb begin
        cif.tick = osc_s2 && !osc_s3;
        cif.restart = wdr_exec;
        cif.run = (mode != WDC_STOP);
        cif.sel = ps;
    end

    // Bus slave and registered outputs; every access takes exactly one wait cycle
    wdc_word_t next_readdata;
    logic next_waitrequest;
    logic next_irq_req;
    logic next_sys_reset;

    always_comb begin
        next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
        next_readdata = avs_readdata;
        if (avs_read && avs_waitrequest) begin
            if (avs_address == `WDC_OFF_CTRL) begin
                next_readdata = rd_ctrl;
            end else if (avs_address == `WDC_OFF_CAUSE) begin
                next_readdata = rd_cause;
            end else begin
                next_readdata = '0;
            end
        end
        next_irq_req = flag && ie_eff && global_irq_enable;
        next_sys_reset = to_rst;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= '0;
            avs_waitrequest <= 1'b1;
            irq_req <= 1'b0;
            sys_reset <= 1'b0;
            reset_vector <= `WDC_RESET_VECTOR;
        end else begin
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
            irq_req <= next_irq_req;
            sys_reset <= next_sys_reset;
            reset_vector <= `WDC_RESET_VECTOR;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_flag_set;
        cif.timeout && mode == WDC_IRQ |=> flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("time-out in interrupt mode left flag clear");

    property p_vector_clear;
        irq_vector_exec && !to_irq |=> !flag;
    endproperty
    a_vector_clear: assert property (p_vector_clear) else $error("vector did not clear flag");

    property p_write_one_clear;
        wr_ctrl && wd[`WDC_BIT_FLAG] && !to_irq |=> !flag;
    endproperty
    a_write_one_clear: assert property (p_write_one_clear) else $error("writing one kept flag");

    property p_write_zero_keep;
        wr_ctrl && !wd[`WDC_BIT_FLAG] && flag && !irq_vector_exec |=> flag;
    endproperty
    a_write_zero_keep: assert property (p_write_zero_keep) else $error("writing zero cleared flag");

    property p_irq_cause;
        irq_req |-> $past(flag) && $past(ie) && !$past(fuse_prog) && $past(global_irq_enable);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt request without cause");

    property p_fuse_reset;
        fuse_prog && cif.timeout |=> sys_reset && !flag || $past(flag);
    endproperty
    a_fuse_reset: assert property (p_fuse_reset) else $error("fuse time-out did not reset");

    property p_first_timeout;
        cif.timeout && mode == WDC_BOTH && !flag |=> flag && !sys_reset;
    endproperty
    a_first_timeout: assert property (p_first_timeout) else $error("combined mode first time-out misbehaved");

    property p_vector_to_reset;
        irq_vector_exec && sre_eff |=> !ie && !flag ##0 (mode == WDC_RST);
    endproperty
    a_vector_to_reset: assert property (p_vector_to_reset) else $error("vector did not return to reset mode");

    property p_unserviced_reset;
        cif.timeout && mode == WDC_BOTH && flag |=> sys_reset && cause;
    endproperty
    a_unserviced_reset: assert property (p_unserviced_reset) else $error("unserviced time-out gave no reset");

    property p_locked_prescale;
        wr_ctrl && !ce |=> $stable(ps);
    endproperty
    a_locked_prescale: assert property (p_locked_prescale) else $error("prescaler changed without unlock");

    property p_ce_expire;
        (wr_ctrl && wd[`WDC_BIT_CE]) ##1 !(wr_ctrl && wd[`WDC_BIT_CE]) [*4] |-> ce ##1 !ce;
    endproperty
    a_ce_expire: assert property (p_ce_expire) else $error("change-enable lifetime wrong");

    property p_cause_holds_sre;
        cause && sre |=> sre;
    endproperty
    a_cause_holds_sre: assert property (p_cause_holds_sre) else $error("reset enable cleared under cause flag");

    c_combined_reset: cover property (mode == WDC_BOTH && flag && cif.timeout ##1 sys_reset);
    c_unlock_change: cover property ((wr_ctrl && wd[`WDC_BIT_CE]) ##[1:4] (wr_ctrl && !wd[`WDC_BIT_CE]));
    c_irq_vector: cover property (irq_req ##[1:20] irq_vector_exec);
endmodule
`default_nettype wire

// [wdc_cpu_model.sv]
// Behavioural CPU side: takes the watchdog interrupt and logs system resets
`timescale 1ns/1ps
`default_nettype none
module wdc_cpu_model (
    input wire logic mclk,
    input wire logic irq_req,
    input wire logic sys_reset,
    input wire wdc_pkg::wdc_vec_t reset_vector,
    input wire logic serve,
    input wire logic [3:0] lat,
    output logic irq_vector_exec,
    output int resets,
    output wdc_pkg::wdc_vec_t last_vec
);
    import wdc_pkg::*;
    initial begin
        irq_vector_exec = 1'b0;
        resets = 0;
        last_vec = 16'hFFFF;
    end
    // Restart address is logged so the bench can judge it
    always @(posedge mclk) begin
        if (sys_reset === 1'b1) begin
            resets <= resets + 1;
            last_vec <= reset_vector;
        end
    end
    // Entry latency varies so a slow handler is also exercised
    always begin
        @(posedge mclk);
        if (serve && irq_req === 1'b1) begin
            repeat (lat) @(posedge mclk);
            irq_vector_exec <= 1'b1;
            @(posedge mclk);
            irq_vector_exec <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    end
endmodule
`default_nettype wire

// [watchdog_control_and_modes_tb.sv]
// Self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module watchdog_control_and_modes_tb;
    import wdc_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    wdc_addr_t addr = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    wdc_word_t wdata = '0;
    wdc_word_t rdata;
    wdc_word_t q;
    logic wait_req;
    logic osc = 1'b0;
    logic fuse = 1'b1;
    logic wdr = 1'b0;
    logic gie = 1'b0;
    logic serve = 1'b0;
    logic [3:0] lat = 4'h1;
    logic vec;
    logic irq;
    logic srst;
    wdc_vec_t rvec;
    wdc_vec_t last_vec;
    logic [3:0] c;
    logic [7:0] p;
    int resets;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed = 32'h795A7430;
    int ticks = 0;
    int t0;

    always #5 mclk = ~mclk;
    // Fast oscillator keeps a 2048-tick time-out near 8k cycles
    always begin
        repeat (2) @(posedge mclk);
        osc <= ~osc;
    end
    always @(posedge osc) ticks++;

    wdc_ctrl dut_u (
        .mclk(mclk), .nrst(nrst), .avs_address(addr), .avs_read(read),
        .avs_write(write), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .osc_pin(osc), .always_on_fuse(fuse),
        .wdr_exec(wdr), .irq_vector_exec(vec), .global_irq_enable(gie),
        .irq_req(irq), .sys_reset(srst), .reset_vector(rvec)
    );
    wdc_cpu_model cpu_u (
        .mclk(mclk), .irq_req(irq), .sys_reset(srst), .reset_vector(rvec),
        .serve(serve), .lat(lat), .irq_vector_exec(vec), .resets(resets),
        .last_vec(last_vec)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 80000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input wdc_word_t seen, input wdc_word_t exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request is held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input wdc_addr_t a, input logic [7:0] d);
        wdc_word_t r;
        r = $random(seed);
        @(posedge mclk);
        read <= ~w;
        write <= w;
        addr <= a;
        wdata <= {r[31:8], d};
        // No local limit: only the cycle ceiling ends a stuck wait
        do @(posedge mclk); while (wait_req !== 1'b0);
        q = rdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input wdc_addr_t a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input wdc_addr_t a, input logic [7:0] e, input string what);
        bus(1'b0, a, 8'h00);
        check(q, {24'h000000, e}, what);
    endtask
    task automatic wait_flag();
        int k;
        k = 0;
        q = '0;
        while (q[7] !== 1'b1 && k < 6000) begin
            bus(1'b0, 4'h0, 8'h00);
            k++;
        end
    endtask
    task automatic wait_irq(input logic v);
        int k;
        k = 0;
        while (irq !== v && k < 20000) begin
            @(posedge mclk);
            k++;
        end
    endtask
    task automatic wait_rst(input int n);
        int k;
        k = 0;
        while (resets != n && k < 20000) begin
            @(posedge mclk);
            k++;
        end
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rd(4'h0, 8'h00, "ctrl reset");
        rd(4'h4, 8'h00, "cause reset");
        wr(4'hC, 8'hFF);
        rd(4'hC, 8'h00, "unmapped read");
        rd(4'h0, 8'h00, "ctrl after unmapped");
        $display("test reset done");
        lat <= 4'(1 + ($random(seed) & 7));
        wr(4'h0, 8'h48);
        wait_flag();
        check(q, 32'h000000C8, "first timeout flag");
        check(resets, 32'h0, "no reset on first");
        check(irq, 32'h0, "irq without global");
        wait_rst(2'd1);
        check(resets, 32'h1, "unserviced second timeout");
        check(last_vec, 32'h0, "restart vector");
        rd(4'h4, 8'h08, "cause set");
        wr(4'h0, 8'h58);
        wr(4'h0, 8'h40);
        rd(4'h0, 8'hC8, "enable held by cause");
        serve <= 1'b1;
        gie <= 1'b1;
        wait_irq(1'b1);
        check(irq, 32'h1, "irq raised");
        wait_irq(1'b0);
        rd(4'h0, 8'h08, "vector clears flag and enable");
        wr(4'h0, 8'h48);
        rd(4'h0, 8'h48, "irq enable set again");
        wr(4'h4, 8'h00);
        rd(4'h4, 8'h00, "cause cleared");
        $display("test combined done");
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h08, "clear needs unlock");
        wr(4'h0, 8'h0A);
        rd(4'h0, 8'h08, "prescale locked");
        c = 4'($unsigned($random(seed)) % 10);
        p = {2'b00, c[3], 2'b00, c[2:0]};
        wr(4'h0, 8'h18);
        wr(4'h0, p);
        rd(4'h0, p, "unlocked write");
        wr(4'h0, 8'h18);
        rd(4'h0, 8'h18 | p, "change window open");
        repeat (3) @(posedge mclk);
        rd(4'h0, 8'h08 | p, "change window closed");
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h08 | p, "late write ignored");
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h00);
        repeat (8400) @(posedge mclk);
        rd(4'h0, 8'h00, "stopped no flag");
        check(resets, 32'h1, "stopped no reset");
        $display("test unlock done");
        fuse <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(4'h0, 8'h08, "fuse forces reset enable");
        wr(4'h0, 8'h40);
        rd(4'h0, 8'h08, "fuse hides irq enable");
        wait_rst(2'd2);
        check(resets, 32'h2, "fuse timeout resets");
        rd(4'h0, 8'h08, "no flag under fuse");
        wr(4'h0, 8'h00);
        fuse <= 1'b1;
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h01);
        $display("test fuse done");
        serve <= 1'b0;
        gie <= 1'b0;
        wr(4'h0, 8'h41);
        wdr <= 1'b1;
        @(posedge mclk);
        wdr <= 1'b0;
        t0 = ticks;
        wait_flag();
        check(32'(ticks - t0 >= 4095 && ticks - t0 <= 4098), 32'h1, "code one period");
        check(irq, 32'h0, "irq needs global");
        wr(4'h0, 8'h41);
        rd(4'h0, 8'hC1, "zero keeps flag");
        wr(4'h0, 8'hC1);
        rd(4'h0, 8'h41, "one clears flag");
        $display("test interrupt done");
        conclude();
    end
endmodule
`default_nettype wire
